// ### design/sensor_cmd_pkg.sv
// Purpose: Shared constants for the sensor command unit
// Assumes: 200 MHz ref_clk
// Notes: Command codes, heater codes, timing counts, checksum helper
package sensor_cmd_pkg;

    // ==========================================================
    // Command bytes
    localparam logic [7:0] CMD_MEAS_HIGH = 8'hFD;
    localparam logic [7:0] CMD_MEAS_MED = 8'hF6;
    localparam logic [7:0] CMD_MEAS_LOW = 8'hE0;
    localparam logic [7:0] CMD_HEAT_200_LONG = 8'h39;
    localparam logic [7:0] CMD_HEAT_200_SHORT = 8'h32;
    localparam logic [7:0] CMD_HEAT_110_LONG = 8'h2F;
    localparam logic [7:0] CMD_HEAT_110_SHORT = 8'h24;
    localparam logic [7:0] CMD_HEAT_20_LONG = 8'h1E;
    localparam logic [7:0] CMD_HEAT_20_SHORT = 8'h15;
    localparam logic [7:0] CMD_READ_SERIAL = 8'h89;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h94;

    // ==========================================================
    // Precision and heater power codes
    localparam logic [1:0] PREC_LOW = 2'h1;
    localparam logic [1:0] PREC_MED = 2'h2;
    localparam logic [1:0] PREC_HIGH = 2'h3;
    localparam logic [1:0] PWR_OFF = 2'h0;
    localparam logic [1:0] PWR_20MW = 2'h1;
    localparam logic [1:0] PWR_110MW = 2'h2;
    localparam logic [1:0] PWR_200MW = 2'h3;

    // ==========================================================
    // Timing
    localparam int CLK_KHZ = 200000;
    localparam int HEAT_LONG_MS = 1000;
    localparam int HEAT_SHORT_MS = 100;
    localparam int HEAT_LONG_CYC = CLK_KHZ * HEAT_LONG_MS;
    localparam int HEAT_SHORT_CYC = CLK_KHZ * HEAT_SHORT_MS;
    localparam int HEAT_CNT_W = 28;

    // ==========================================================
    // Result frame and checksum
    localparam int RES_BYTES = 6;
    localparam logic [2:0] RES_LAST = 3'h5;
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam int FIFO_DEPTH = 4;
    localparam int BYTE_W = 8;

    // CRC-8, MSB first, no reflection, no final xor
    function automatic logic [7:0] crc8(input logic [15:0] word);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ word[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

// ### design/byte_fifo.sv
// Purpose: Small shift-register FIFO with registered head
// Assumes: Single clock, synchronous active-low reset
// Notes: Head slot is a flop so outputs need no read mux
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    logic [DEPTH-1:0] vld_q;
    logic [WIDTH-1:0] dat_q [DEPTH];
    logic [DEPTH-1:0] sh_vld;
    logic [WIDTH-1:0] sh_dat [DEPTH];
    logic pop;
    logic push;

    // ==========================================================
    // Shift on pop, then fill first empty slot
    assign pop = vld_q[0] && out_ready;
    assign in_ready = !vld_q[DEPTH-1];
    assign push = in_valid && in_ready;
    assign out_valid = vld_q[0];
    assign out_data = dat_q[0];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            if (pop) begin
                sh_vld[i] = (i < DEPTH - 1) ? vld_q[(i + 1) % DEPTH] : 1'b0;
                sh_dat[i] = (i < DEPTH - 1) ? dat_q[(i + 1) % DEPTH]
                                            : dat_q[i];
            end else begin
                sh_vld[i] = vld_q[i];
                sh_dat[i] = dat_q[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || flush) begin
            vld_q <= '0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                vld_q[i] <= sh_vld[i] || (push && !sh_vld[i] &&
                            (i == 0 || sh_vld[(i + DEPTH - 1) % DEPTH]));
            end
        end
    end

    // Data needs no reset; valid bits guard it
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !sh_vld[i] &&
                (i == 0 || sh_vld[(i + DEPTH - 1) % DEPTH])) begin
                dat_q[i] <= in_data;
            end else begin
                dat_q[i] <= sh_dat[i];
            end
        end
    end

endmodule // byte_fifo

// ### design/humidity_cmd_unit.sv
// Purpose: Command unit of a humidity and temperature sensor
// Assumes: Serial bus target logic delivers bytes on ref_clk
// Notes: Analog front end handshakes by start pulse and done level
//
// Summary of operation
// - Command FD starts one high repeatability measurement, result kept.
// - Command F6 starts one medium repeatability measurement, result kept.
// - Command E0 starts one low repeatability measurement, result kept.
// - Result is temperature word, its CRC, humidity word, its CRC.
// - Command 39: heater 200 mW for 1 s, high measurement, heater off.
// - Command 32: heater 200 mW for 0.1 s, high measurement, heater off.
// - Command 2F: heater 110 mW for 1 s, high measurement, heater off.
// - Command 24: heater 110 mW for 0.1 s, high measurement, heater off.
// - Command 1E: heater 20 mW for 1 s, high measurement, heater off.
// - Command 15: heater 20 mW for 0.1 s, high measurement, heater off.
// - Command 89 returns serial number as two words, each with CRC.
// - Serial number is fixed per unit; no command changes it.
// - Command 94 soft resets the unit and is acknowledged.
// - Read header while busy is refused with a not-acknowledge.
// - First acknowledged read header discards result; read once only.
`timescale 1ns/1ps
module humidity_cmd_unit #(
    parameter logic [31:0] SERIAL_NUMBER = 32'h5A3C_0F96, // arbitrary
    parameter int HEAT_LONG_CYC = sensor_cmd_pkg::HEAT_LONG_CYC,
    parameter int HEAT_SHORT_CYC = sensor_cmd_pkg::HEAT_SHORT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    output logic cmd_ack,
    input wire logic rd_hdr,
    output logic rd_hdr_ack,
    output logic rd_hdr_nack,
    output logic tx_valid,
    output logic [sensor_cmd_pkg::BYTE_W-1:0] tx_byte,
    input wire logic tx_ready,
    output logic meas_start,
    output logic [1:0] meas_prec,
    input wire logic meas_done,
    input wire logic [15:0] raw_temperature_word,
    input wire logic [15:0] raw_humidity_word,
    output logic heater_on,
    output logic [1:0] heater_power
);
    import sensor_cmd_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HEAT = 5'h02,
        ST_MEAS = 5'h04,
        ST_READY = 5'h08,
        ST_SEND = 5'h10
    } state_t;

    state_t state_q;
    logic [HEAT_CNT_W-1:0] heat_cnt_q;
    logic [7:0] res_q [RES_BYTES];
    logic [2:0] idx_q;
    logic cmd_ack_q, rd_hdr_ack_q, rd_hdr_nack_q;
    logic meas_start_q, heater_on_q;
    logic [1:0] meas_prec_q, heater_power_q;
    logic done_s1_q, done_s2_q, done_s3_q, done_lvl_q, done_prev_q;
    logic done_rise, soft_reset, cmd_go, heat_end, new_work;
    logic is_meas, is_heat, is_serial, heat_long;
    logic [1:0] c_prec, c_pwr;
    logic fifo_ready;

    // ==========================================================
    // Command decode
    assign soft_reset = cmd_valid && cmd_byte == CMD_SOFT_RESET;
    // New work only when idle or holding an unread result
    assign cmd_go = cmd_valid && (state_q == ST_IDLE ||
                                  state_q == ST_READY);
    assign new_work = cmd_go && (is_meas || is_heat || is_serial);
    assign heat_end = state_q == ST_HEAT && heat_cnt_q == '0;

    always_comb begin
        is_meas = 1'b0;
        is_heat = 1'b0;
        is_serial = 1'b0;
        heat_long = 1'b0;
        c_prec = PREC_HIGH;
        c_pwr = PWR_OFF;
        unique case (cmd_byte)
            CMD_MEAS_HIGH: is_meas = 1'b1;
            CMD_MEAS_MED: begin
                is_meas = 1'b1;
                c_prec = PREC_MED;
            end
            CMD_MEAS_LOW: begin
                is_meas = 1'b1;
                c_prec = PREC_LOW;
            end
            CMD_HEAT_200_LONG, CMD_HEAT_200_SHORT: begin
                is_heat = 1'b1;
                c_pwr = PWR_200MW;
                heat_long = cmd_byte == CMD_HEAT_200_LONG;
            end
            CMD_HEAT_110_LONG, CMD_HEAT_110_SHORT: begin
                is_heat = 1'b1;
                c_pwr = PWR_110MW;
                heat_long = cmd_byte == CMD_HEAT_110_LONG;
            end
            CMD_HEAT_20_LONG, CMD_HEAT_20_SHORT: begin
                is_heat = 1'b1;
                c_pwr = PWR_20MW;
                heat_long = cmd_byte == CMD_HEAT_20_LONG;
            end
            CMD_READ_SERIAL: is_serial = 1'b1;
            default: ;
        endcase
    end

    // ==========================================================
    // Done synchroniser: analog side is asynchronous
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
            done_lvl_q <= 1'b0;
            done_prev_q <= 1'b0;
        end else begin
            done_s1_q <= meas_done;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            if (done_s2_q == done_s3_q) begin
                done_lvl_q <= done_s3_q;
            end
            done_prev_q <= done_lvl_q;
        end
    end
    assign done_rise = done_lvl_q && !done_prev_q;

    // ==========================================================
    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_READY: begin
                    if (cmd_go && is_meas) begin
                        state_q <= ST_MEAS;
                    end else if (cmd_go && is_heat) begin
                        state_q <= ST_HEAT;
                    end else if (cmd_go && is_serial) begin
                        state_q <= ST_READY;
                    end else if (state_q == ST_READY && rd_hdr) begin
                        state_q <= ST_SEND;
                    end
                end
                ST_HEAT: if (heat_end) state_q <= ST_MEAS;
                ST_MEAS: if (done_rise) state_q <= ST_READY;
                ST_SEND: begin
                    if (fifo_ready && idx_q == RES_LAST) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Heater dwell counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            heat_cnt_q <= '0;
        end else if (cmd_go && is_heat) begin
            heat_cnt_q <= heat_long ? HEAT_CNT_W'(HEAT_LONG_CYC - 1)
                                    : HEAT_CNT_W'(HEAT_SHORT_CYC - 1);
        end else if (state_q == ST_HEAT && heat_cnt_q != '0) begin
            heat_cnt_q <= heat_cnt_q - 1'b1;
        end
    end

    // Heater stays on through the measurement, off at its end
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            heater_on_q <= 1'b0;
            heater_power_q <= PWR_OFF;
        end else if (cmd_go && is_heat) begin
            heater_on_q <= 1'b1;
            heater_power_q <= c_pwr;
        end else if (state_q == ST_MEAS && done_rise) begin
            heater_on_q <= 1'b0;
            heater_power_q <= PWR_OFF;
        end
    end

    // Measurement request to the front end
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            meas_start_q <= 1'b0;
            meas_prec_q <= PREC_HIGH;
        end else begin
            meas_start_q <= (cmd_go && is_meas) || heat_end;
            if (cmd_go && is_meas) begin
                meas_prec_q <= c_prec;
            end else if (cmd_go && is_heat) begin
                meas_prec_q <= PREC_HIGH;
            end
        end
    end

    // ==========================================================
    // Result frame, filled once per measurement or serial read
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            for (int i = 0; i < RES_BYTES; i++) res_q[i] <= 8'h00;
        end else if (state_q == ST_MEAS && done_rise) begin
            res_q[0] <= raw_temperature_word[15:8];
            res_q[1] <= raw_temperature_word[7:0];
            res_q[2] <= crc8(raw_temperature_word);
            res_q[3] <= raw_humidity_word[15:8];
            res_q[4] <= raw_humidity_word[7:0];
            res_q[5] <= crc8(raw_humidity_word);
        end else if (cmd_go && is_serial) begin
            // Parameter only: nothing can overwrite the serial
            res_q[0] <= SERIAL_NUMBER[31:24];
            res_q[1] <= SERIAL_NUMBER[23:16];
            res_q[2] <= crc8(SERIAL_NUMBER[31:16]);
            res_q[3] <= SERIAL_NUMBER[15:8];
            res_q[4] <= SERIAL_NUMBER[7:0];
            res_q[5] <= crc8(SERIAL_NUMBER[15:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset || state_q != ST_SEND) begin
            idx_q <= 3'h0;
        end else if (fifo_ready) begin
            idx_q <= idx_q + 3'h1;
        end
    end

    // ==========================================================
    // Handshake answers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmd_ack_q <= 1'b0;
            rd_hdr_ack_q <= 1'b0;
            rd_hdr_nack_q <= 1'b0;
        end else begin
            cmd_ack_q <= soft_reset || new_work;
            rd_hdr_ack_q <= rd_hdr && !soft_reset && !new_work &&
                            state_q == ST_READY;
            // No clock stretching: busy or empty refuses at once
            rd_hdr_nack_q <= rd_hdr && (soft_reset || new_work ||
                             state_q != ST_READY);
        end
    end

    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .flush(soft_reset),
        .in_valid(state_q == ST_SEND),
        .in_data(res_q[idx_q]),
        .in_ready(fifo_ready),
        .out_valid(tx_valid),
        .out_data(tx_byte),
        .out_ready(tx_ready)
    );

    assign cmd_ack = cmd_ack_q;
    assign rd_hdr_ack = rd_hdr_ack_q;
    assign rd_hdr_nack = rd_hdr_nack_q;
    assign meas_start = meas_start_q;
    assign meas_prec = meas_prec_q;
    assign heater_on = heater_on_q;
    assign heater_power = heater_power_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic idle_cmd;
    assign idle_cmd = cmd_valid && state_q == ST_IDLE;

    meas_high_a: assert property (idle_cmd && cmd_byte == CMD_MEAS_HIGH
        |=> meas_start && meas_prec == PREC_HIGH && state_q == ST_MEAS)
        else $error("high measurement not started");
    meas_med_a: assert property (idle_cmd && cmd_byte == CMD_MEAS_MED
        |=> meas_start && meas_prec == PREC_MED)
        else $error("medium measurement not started");
    meas_low_a: assert property (idle_cmd && cmd_byte == CMD_MEAS_LOW
        |=> meas_start && meas_prec == PREC_LOW)
        else $error("low measurement not started");
    heat_200_a: assert property (idle_cmd &&
        cmd_byte == CMD_HEAT_200_LONG |=> heater_on && heater_power ==
        PWR_200MW && heat_cnt_q == HEAT_CNT_W'(HEAT_LONG_CYC - 1))
        else $error("heater 200 mW long not set");
    heat_20s_a: assert property (idle_cmd &&
        cmd_byte == CMD_HEAT_20_SHORT |=> heater_power == PWR_20MW &&
        heat_cnt_q == HEAT_CNT_W'(HEAT_SHORT_CYC - 1))
        else $error("heater 20 mW short not set");
    heat_off_a: assert property (state_q == ST_MEAS && done_rise
        && !soft_reset |=> !heater_on && state_q == ST_READY)
        else $error("heater left on after measurement");
    frame_crc_a: assert property (state_q == ST_READY |->
        crc8(16'hBEEF) == 8'h92 && res_q[2] == crc8({res_q[0], res_q[1]}) &&
        res_q[5] == crc8({res_q[3], res_q[4]}))
        else $error("result checksum mismatch");
    hdr_busy_a: assert property (rd_hdr && state_q != ST_READY
        |=> rd_hdr_nack && !rd_hdr_ack)
        else $error("busy header not refused");
    read_once_a: assert property (rd_hdr && state_q == ST_READY &&
        !cmd_valid |=> rd_hdr_ack && state_q == ST_SEND)
        else $error("result not released after read");
    soft_reset_a: assert property (soft_reset |=> cmd_ack && !heater_on
        && state_q == ST_IDLE && !tx_valid)
        else $error("soft reset incomplete");

    heated_read_c: cover property (state_q == ST_HEAT ##[1:1000]
        state_q == ST_READY ##[1:1000] rd_hdr_ack);
    serial_read_c: cover property (idle_cmd && cmd_byte == CMD_READ_SERIAL
        ##[1:1000] rd_hdr_ack);
    reset_heat_c: cover property (state_q == ST_HEAT && soft_reset);

endmodule // humidity_cmd_unit

// ### verif/front_end_model.sv
// Purpose: Behavioural analog front end facing the command unit
// Assumes: One conversion at a time, started by a one-cycle pulse
// Notes: Words scramble while converting, so stale values never pass
`timescale 1ns/1ps
module front_end_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic meas_start,
    input wire logic [15:0] next_temp,
    input wire logic [15:0] next_hum,
    input wire logic [15:0] latency,
    output logic meas_done,
    output logic [15:0] raw_temperature_word,
    output logic [15:0] raw_humidity_word
);
    // ==========================================================
    // Conversion
    logic [15:0] cnt_q;
    logic busy_q;

    // Latency is a level from the bench, so prompt and slow both occur
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            busy_q <= 1'b0;
            meas_done <= 1'b0;
            raw_temperature_word <= 16'h0000;
            raw_humidity_word <= 16'h0000;
        end else if (meas_start) begin
            busy_q <= 1'b1;
            cnt_q <= latency;
            meas_done <= 1'b0;
        end else if (busy_q) begin
            if (cnt_q == 16'h0000) begin
                busy_q <= 1'b0;
                meas_done <= 1'b1;
                raw_temperature_word <= next_temp;
                raw_humidity_word <= next_hum;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
                raw_temperature_word <= ~raw_temperature_word;
                raw_humidity_word <= ~raw_humidity_word;
            end
        end
    end
endmodule // front_end_model

// ### verif/humidity_temp_sensor_command_unit_tb.sv
// Purpose: Self-checking bench for the sensor command unit
// Assumes: Shortened heater counts; front end model on the far side
// Notes: Reads stall the consumer first so the FIFO fills and refuses
`timescale 1ns/1ps
module humidity_temp_sensor_command_unit_tb;
    import sensor_cmd_pkg::*;
    localparam int HL = 40;
    localparam int HS = 10;
    localparam logic [31:0] SN = 32'hC0DE_1357; // arbitrary
    logic ref_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, rd_hdr = 1'b0;
    logic tx_ready = 1'b0, stall = 1'b1;
    logic [7:0] cmd_byte = 8'h00;
    logic cmd_ack, rd_hdr_ack, rd_hdr_nack, tx_valid, meas_start, meas_done;
    logic heater_on;
    logic [1:0] meas_prec, heater_power;
    logic [7:0] tx_byte;
    logic [15:0] raw_t, raw_h;
    logic [15:0] next_t = 16'h0000, next_h = 16'h0000, lat = 16'h0005;
    logic [31:0] seed = 32'h0000_005C;
    int failures = 0, n_checks = 0, cyc = 0, since = 0, ms_gap = 0;
    int n_ack = 0, n_hack = 0, n_nack = 0, n_ms = 0, m0 = 0;
    logic [7:0] rxq[$];
    logic [7:0] cmds[9] = '{CMD_MEAS_HIGH, CMD_MEAS_MED, CMD_MEAS_LOW,
        CMD_HEAT_200_LONG, CMD_HEAT_200_SHORT, CMD_HEAT_110_LONG,
        CMD_HEAT_110_SHORT, CMD_HEAT_20_LONG, CMD_HEAT_20_SHORT};
    logic [1:0] precs[9] = '{PREC_HIGH, PREC_MED, PREC_LOW, PREC_HIGH,
        PREC_HIGH, PREC_HIGH, PREC_HIGH, PREC_HIGH, PREC_HIGH};
    logic [1:0] pws[9] = '{PWR_OFF, PWR_OFF, PWR_OFF, PWR_200MW, PWR_200MW,
        PWR_110MW, PWR_110MW, PWR_20MW, PWR_20MW};
    int gaps[9] = '{0, 0, 0, HL, HS, HL, HS, HL, HS};

    // ==========================================================
    // Design and far side
    humidity_cmd_unit #(.SERIAL_NUMBER(SN), .HEAT_LONG_CYC(HL),
        .HEAT_SHORT_CYC(HS)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ack(cmd_ack),
        .rd_hdr(rd_hdr), .rd_hdr_ack(rd_hdr_ack), .rd_hdr_nack(rd_hdr_nack),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .meas_start(meas_start), .meas_prec(meas_prec),
        .meas_done(meas_done), .raw_temperature_word(raw_t),
        .raw_humidity_word(raw_h), .heater_on(heater_on),
        .heater_power(heater_power));
    front_end_model u_front (.ref_clk(ref_clk), .rst_n(rst_n),
        .meas_start(meas_start), .next_temp(next_t), .next_hum(next_h),
        .latency(lat), .meas_done(meas_done),
        .raw_temperature_word(raw_t), .raw_humidity_word(raw_h));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] crc_ref(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ (((c[7] ^ w[i]) == 1'b1) ? 8'h31 : 8'h00);
        end
        return c;
    endfunction

    function automatic logic [47:0] frame(input logic [15:0] a,
                                          input logic [15:0] b);
        return {a, crc_ref(a), b, crc_ref(b)};
    endfunction

    // Host view of a raw word; humidity clamped to a physical range
    function automatic int to_phys(input logic [15:0] raw, input int off,
                                   input int span, input bit clamp);
        int v;
        v = off + (span * int'(raw)) / 65535;
        if (clamp) v = (v < 0) ? 0 : ((v > 100) ? 100 : v);
        return v;
    endfunction

    task automatic check(input string what, input logic [47:0] seen,
                         input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Monitor and consumer; counts survive any sampling skew
    always @(posedge ref_clk) begin
        cyc++;
        since++;
        if (cmd_ack === 1'b1) begin
            n_ack++;
            since = 0;
        end
        if (meas_start === 1'b1) begin
            n_ms++;
            ms_gap = since;
        end
        if (rd_hdr_ack === 1'b1) n_hack++;
        if (rd_hdr_nack === 1'b1) n_nack++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) rxq.push_back(tx_byte);
        tx_ready <= stall ? 1'b0 : ((rnd() & 32'h0000_0003) != 0);
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic send(input logic [7:0] b, input int acks);
        int a0;
        a0 = n_ack;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_byte <= b;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("cmd_ack count", 48'(n_ack - a0), 48'(acks));
    endtask

    task automatic read(input string what, input logic ok,
                        input logic [47:0] exp);
        int h0, n0, k;
        h0 = n_hack;
        n0 = n_nack;
        rxq.delete();
        @(posedge ref_clk);
        rd_hdr <= 1'b1;
        stall <= 1'b1;
        @(posedge ref_clk);
        rd_hdr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({what, " ack"}, 48'(n_hack - h0), 48'(ok));
        check({what, " nack"}, 48'(n_nack - n0), 48'(!ok));
        k = 0;
        while (ok && rxq.size() < 6 && k < 300) begin
            @(posedge ref_clk);
            k++;
            if (k == 20) begin
                check({what, " head"}, 48'(tx_byte), 48'(exp[47:40]));
                stall <= 1'b0;
            end
        end
        repeat (4) @(posedge ref_clk);
        #1;
        if (ok) check(what, {rxq[0], rxq[1], rxq[2], rxq[3], rxq[4], rxq[5]},
                      exp);
        check({what, " count"}, 48'(rxq.size()), ok ? 48'd6 : 48'd0);
    endtask

    task automatic wait_done();
        int k;
        k = 0;
        while (meas_done !== 1'b1 && k < 400) begin
            @(posedge ref_clk);
            k++;
        end
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        read("empty", 1'b0, 48'h0000_0000_0000);
        send(8'h00, 0);
        for (int i = 0; i < 9; i++) begin
            @(posedge ref_clk);
            next_t <= 16'(rnd());
            next_h <= 16'(rnd());
            lat <= 16'(3 + rnd() % 20);
            m0 = n_ms;
            send(cmds[i], 1);
            for (int k = 0; k < 300 && n_ms == m0; k++) @(posedge ref_clk);
            #1;
            check("start delay", 48'(ms_gap >= gaps[i] &&
                  ms_gap <= gaps[i] + 3), 48'd1);
            check("precision", 48'(meas_prec), 48'(precs[i]));
            check("heater", 48'({heater_on, heater_power}), 48'({
                  pws[i] != PWR_OFF, pws[i]}));
            wait_done();
            check("heater off", 48'(heater_on), 48'd0);
            read("result", 1'b1, frame(next_t, next_h));
            check("deg C", 48'(to_phys({rxq[0], rxq[1]}, -45, 175, 1'b0)),
                  48'(to_phys(next_t, -45, 175, 1'b0)));
            check("rh pct", 48'(to_phys({rxq[3], rxq[4]}, -6, 125, 1'b1)),
                  48'(to_phys(next_h, -6, 125, 1'b1)));
            read("reread", 1'b0, 48'h0000_0000_0000);
        end
        $display("test commands done");
        for (int i = 0; i < 2; i++) begin
            send(CMD_READ_SERIAL, 1);
            repeat (3) @(posedge ref_clk);
            read("serial", 1'b1, frame(SN[31:16], SN[15:0]));
        end
        $display("test serial done");
        @(posedge ref_clk);
        lat <= 16'h00C8;
        send(CMD_MEAS_HIGH, 1);
        read("busy", 1'b0, 48'h0000_0000_0000);
        send(CMD_MEAS_LOW, 0);
        send(CMD_SOFT_RESET, 1);
        repeat (250) @(posedge ref_clk);
        read("aborted", 1'b0, 48'h0000_0000_0000);
        send(CMD_HEAT_200_LONG, 1);
        check("heating", 48'(heater_on), 48'd1);
        m0 = n_ms;
        send(CMD_SOFT_RESET, 1);
        check("heat abort", 48'(heater_on), 48'd0);
        repeat (60) @(posedge ref_clk);
        check("no start", 48'(n_ms - m0), 48'd0);
        @(posedge ref_clk);
        lat <= 16'h0004;
        send(CMD_MEAS_MED, 1);
        wait_done();
        send(CMD_SOFT_RESET, 1);
        read("dropped", 1'b0, 48'h0000_0000_0000);
        $display("test soft reset done");
        end_of_test();
    end
endmodule // humidity_temp_sensor_command_unit_tb
